/* verilog/irq_pkg.sv */
package irq_pkg;

   // Register byte addresses
   localparam logic [7:0] MAIN_IRQ_CONTROL_OFS   = 8'h00;
   localparam logic [7:0] SECOND_IRQ_CONTROL_OFS = 8'h04;
   localparam logic [7:0] THIRD_IRQ_CONTROL_OFS  = 8'h08;
   localparam logic [7:0] PERIPHERAL_PRIO_2_OFS  = 8'h0C;
   localparam logic [7:0] RESET_CAUSE_CTRL_OFS   = 8'h10;
   localparam logic [7:0] TIMER_ZERO_LOW_OFS     = 8'h14;
   localparam logic [7:0] TIMER_ZERO_HIGH_OFS    = 8'h18;
   localparam logic [7:0] TIMER_ZERO_CONFIG_OFS  = 8'h1C;

   // Register index after decode
   typedef enum logic [3:0] {
      REG_MAIN   = 4'h0,
      REG_SECOND = 4'h1,
      REG_THIRD  = 4'h2,
      REG_PRIO2  = 4'h3,
      REG_RCAUSE = 4'h4,
      REG_TLOW   = 4'h5,
      REG_THIGH  = 4'h6,
      REG_TCFG   = 4'h7,
      REG_NONE   = 4'hF
   } reg_index_type;

   // Main control fields
   localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
   localparam int PERIPH_IRQ_ENABLE_BIT = 6;
   localparam int TIMER_ZERO_EN_BIT     = 5;
   localparam int EXT_ZERO_EN_BIT       = 4;
   localparam int PORT_CHANGE_EN_BIT    = 3;
   localparam int TIMER_ZERO_FLAG_BIT   = 2;
   localparam int EXT_ZERO_FLAG_BIT     = 1;
   localparam int PORT_CHANGE_FLAG_BIT  = 0;

   // Second control fields
   localparam int EDGE_SEL_ZERO_BIT     = 6;
   localparam int EDGE_SEL_ONE_BIT      = 5;
   localparam int EDGE_SEL_TWO_BIT      = 4;
   localparam int TIMER_ZERO_PRIO_BIT   = 2;
   localparam int PORT_CHANGE_PRIO_BIT  = 0;

   // Third control fields
   localparam int EXT_TWO_PRIO_BIT      = 7;
   localparam int EXT_ONE_PRIO_BIT      = 6;
   localparam int EXT_TWO_EN_BIT        = 4;
   localparam int EXT_ONE_EN_BIT        = 3;
   localparam int EXT_TWO_FLAG_BIT      = 1;
   localparam int EXT_ONE_FLAG_BIT      = 0;

   // Reset cause control fields
   localparam int PRIO_LEVELS_EN_BIT    = 7;
   localparam int WATCHDOG_TIMEOUT_BIT  = 3;
   localparam int POWER_DOWN_BIT        = 2;

   // Timer config fields
   localparam int TIMER_SIXTEEN_BIT     = 0;

   // Reset values and masks
   localparam logic [7:0] PERIPHERAL_PRIO_2_RST  = 8'hDF;
   localparam logic [7:0] PERIPHERAL_PRIO_2_MASK = 8'hDF;
   localparam logic [7:0] RESET_CAUSE_RST        = 8'h5C;
   localparam logic [7:0] RESET_CAUSE_WMASK      = 8'hD3;
   localparam logic [7:0] SECOND_CTRL_RST        = 8'h75;
   localparam logic [7:0] SECOND_CTRL_MASK       = 8'h75;
   localparam logic [7:0] THIRD_CTRL_RST         = 8'hC0;
   localparam logic [7:0] THIRD_CTRL_MASK        = 8'hDB;
   localparam logic [7:0] BYTE_ZERO              = 8'h00;
   localparam logic [7:0] BYTE_ONES              = 8'hFF;

   // Pin synchroniser depth
   localparam int SYNC_STAGES = 3;

endpackage : irq_pkg

/* verilog/pin_filter.sv */
`timescale 1ns/1ps

// Three-stage pin synchroniser; output follows once stages two and three agree
module pin_filter #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] pin_async,
   output logic      [WIDTH-1:0] pin_stable
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] late_q;
   logic [WIDTH-1:0] stable_q;

   // Chain; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
         late_q <= '0;
      end else begin
         meta_q <= pin_async;
         sync_q <= meta_q;
         late_q <= sync_q;
      end
   end

   // Accept a level once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_q <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (sync_q[i] == late_q[i]) begin
               stable_q[i] <= late_q[i];
            end
         end
      end
   end

   assign pin_stable = stable_q;

endmodule : pin_filter

/* verilog/irq_ctrl.sv */
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps

module irq_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic [2:0]  ext_irq_pins,
   input  wire logic [3:0]  port_b_pins,
   input  wire logic        timer_zero_tick,
   input  wire logic [7:0]  periph_two_pending,
   input  wire logic [7:0]  periph_one_pending,
   input  wire logic [7:0]  periph_one_prio,
   input  wire logic        watchdog_timeout_flag,
   input  wire logic        power_down_flag,
   input  wire logic        irq_entry,
   input  wire logic [20:0] return_pc,
   input  wire logic [7:0]  working_register,
   input  wire logic [7:0]  status_register,
   input  wire logic [7:0]  bank_select_register,
   output logic             irq_high_q,
   output logic             irq_low_q,
   output logic             wake_q,
   output logic             stack_push_q,
   output logic [20:0]      stack_pc_q,
   output logic [7:0]       shadow_working_q,
   output logic [7:0]       shadow_status_q,
   output logic [7:0]       shadow_bank_q
);

   logic [7:3]  main_ctl_q;
   logic [2:0]  ext_flag_q;
   logic        timer_flag_q;
   logic        port_flag_q;
   logic [7:0]  second_ctl_q;
   logic [7:0]  third_ctl_q;
   logic [7:0]  prio_two_q;
   logic [7:0]  rcause_q;
   logic [7:0]  tlow_q;
   logic [7:0]  thigh_q;
   logic        sixteen_q;
   logic [2:0]  ext_stable;
   logic [3:0]  port_stable;
   logic [2:0]  ext_prev_q;
   logic [3:0]  port_prev_q;
   logic [2:0]  ext_edge;
   logic [2:0]  edge_sel;
   logic [2:0]  ext_en;
   logic        port_change;
   logic        timer_roll;
   logic        wr_en;
   logic        rd_setup;
   logic [7:0]  wbyte;
   logic [7:0]  rd_byte;
   logic        priority_levels_enable;
   logic        global_irq_enable;
   logic        peripheral_irq_enable;
   logic        high_any;
   logic        low_any;
   logic [7:0]  prio_eff_two;
   logic [7:0]  prio_eff_one;
   logic        p_tmr;
   logic        p_port;
   logic [2:0]  p_ext;
   logic        core_pend;
   logic        core_high;
   logic        core_low;
   irq_pkg::reg_index_type idx;

   // Address decode shared by reads and writes
   function automatic irq_pkg::reg_index_type decode(input logic [7:0] a);
      if (a == irq_pkg::MAIN_IRQ_CONTROL_OFS) return irq_pkg::REG_MAIN;
      else if (a == irq_pkg::SECOND_IRQ_CONTROL_OFS) return irq_pkg::REG_SECOND;
      else if (a == irq_pkg::THIRD_IRQ_CONTROL_OFS) return irq_pkg::REG_THIRD;
      else if (a == irq_pkg::PERIPHERAL_PRIO_2_OFS) return irq_pkg::REG_PRIO2;
      else if (a == irq_pkg::RESET_CAUSE_CTRL_OFS) return irq_pkg::REG_RCAUSE;
      else if (a == irq_pkg::TIMER_ZERO_LOW_OFS) return irq_pkg::REG_TLOW;
      else if (a == irq_pkg::TIMER_ZERO_HIGH_OFS) return irq_pkg::REG_THIGH;
      else if (a == irq_pkg::TIMER_ZERO_CONFIG_OFS) return irq_pkg::REG_TCFG;
      else return irq_pkg::REG_NONE;
   endfunction : decode

   // Pin synchronisers
   pin_filter #(.WIDTH(3)) u_ext_sync (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_async  (ext_irq_pins),
      .pin_stable (ext_stable)
   );

   pin_filter #(.WIDTH(4)) u_port_sync (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_async  (port_b_pins),
      .pin_stable (port_stable)
   );

   // Bus strobes
   assign idx      = decode(paddr);
   assign wr_en    = psel & penable & pwrite & (idx != irq_pkg::REG_NONE);
   assign rd_setup = psel & ~penable;
   assign wbyte    = pwdata[7:0];
   assign pready   = 1'b1;

   // Edge and change detection
   assign edge_sel = {second_ctl_q[irq_pkg::EDGE_SEL_TWO_BIT],
                      second_ctl_q[irq_pkg::EDGE_SEL_ONE_BIT],
                      second_ctl_q[irq_pkg::EDGE_SEL_ZERO_BIT]};
   assign ext_edge = (edge_sel & ext_stable & ~ext_prev_q)
                   | (~edge_sel & ~ext_stable & ext_prev_q);
   assign port_change = |(port_stable ^ port_prev_q);
   assign timer_roll  = timer_zero_tick & (tlow_q == irq_pkg::BYTE_ONES)
                      & (~sixteen_q | (thigh_q == irq_pkg::BYTE_ONES));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev_q  <= '0;
         port_prev_q <= '0;
      end else begin
         ext_prev_q  <= ext_stable;
         port_prev_q <= port_stable;
      end
   end

   // Main control enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_ctl_q <= '0;
      end else if (wr_en && idx == irq_pkg::REG_MAIN) begin
         main_ctl_q <= wbyte[7:3];
      end
   end

   // Flags: hardware set wins over software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_flag_q   <= '0;
         timer_flag_q <= 1'b0;
         port_flag_q  <= 1'b0;
      end else begin
         if (wr_en && idx == irq_pkg::REG_MAIN) begin
            ext_flag_q[0] <= wbyte[irq_pkg::EXT_ZERO_FLAG_BIT] | ext_edge[0];
            timer_flag_q  <= wbyte[irq_pkg::TIMER_ZERO_FLAG_BIT] | timer_roll;
            port_flag_q   <= wbyte[irq_pkg::PORT_CHANGE_FLAG_BIT] | port_change;
         end else begin
            ext_flag_q[0] <= ext_flag_q[0] | ext_edge[0];
            timer_flag_q  <= timer_flag_q | timer_roll;
            port_flag_q   <= port_flag_q | port_change;
         end
         if (wr_en && idx == irq_pkg::REG_THIRD) begin
            ext_flag_q[1] <= wbyte[irq_pkg::EXT_ONE_FLAG_BIT] | ext_edge[1];
            ext_flag_q[2] <= wbyte[irq_pkg::EXT_TWO_FLAG_BIT] | ext_edge[2];
         end else begin
            ext_flag_q[2:1] <= ext_flag_q[2:1] | ext_edge[2:1];
         end
      end
   end

   // Second and third control, peripheral priority two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_ctl_q <= irq_pkg::SECOND_CTRL_RST;
         third_ctl_q  <= irq_pkg::THIRD_CTRL_RST;
         prio_two_q   <= irq_pkg::PERIPHERAL_PRIO_2_RST;
      end else if (wr_en) begin
         if (idx == irq_pkg::REG_SECOND) begin
            second_ctl_q <= wbyte & irq_pkg::SECOND_CTRL_MASK;
         end else if (idx == irq_pkg::REG_THIRD) begin
            third_ctl_q <= wbyte & irq_pkg::THIRD_CTRL_MASK;
         end else if (idx == irq_pkg::REG_PRIO2) begin
            prio_two_q <= wbyte & irq_pkg::PERIPHERAL_PRIO_2_MASK;
         end
      end
   end

   // Reset cause control; timeout and power-down follow their inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rcause_q <= irq_pkg::RESET_CAUSE_RST;
      end else begin
         if (wr_en && idx == irq_pkg::REG_RCAUSE) begin
            rcause_q <= (wbyte & irq_pkg::RESET_CAUSE_WMASK)
                      | (rcause_q & ~irq_pkg::RESET_CAUSE_WMASK);
         end
         rcause_q[irq_pkg::WATCHDOG_TIMEOUT_BIT] <= watchdog_timeout_flag;
         rcause_q[irq_pkg::POWER_DOWN_BIT]       <= power_down_flag;
      end
   end

   // Timer zero counter and mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tlow_q    <= irq_pkg::BYTE_ZERO;
         thigh_q   <= irq_pkg::BYTE_ZERO;
         sixteen_q <= 1'b0;
      end else begin
         if (wr_en && idx == irq_pkg::REG_TLOW) begin
            tlow_q <= wbyte;
         end else if (timer_zero_tick) begin
            tlow_q <= tlow_q + 8'h01;
         end
         if (wr_en && idx == irq_pkg::REG_THIGH) begin
            thigh_q <= wbyte;
         end else if (timer_zero_tick && sixteen_q && tlow_q == irq_pkg::BYTE_ONES) begin
            thigh_q <= thigh_q + 8'h01;
         end
         if (wr_en && idx == irq_pkg::REG_TCFG) begin
            sixteen_q <= wbyte[irq_pkg::TIMER_SIXTEEN_BIT];
         end
      end
   end

   // Read mux
   always_comb begin
      rd_byte = irq_pkg::BYTE_ZERO;
      case (idx)
         irq_pkg::REG_MAIN:   rd_byte = {main_ctl_q, timer_flag_q, ext_flag_q[0], port_flag_q};
         irq_pkg::REG_SECOND: rd_byte = second_ctl_q;
         irq_pkg::REG_THIRD:  rd_byte = {third_ctl_q[7:2], ext_flag_q[2:1]};
         irq_pkg::REG_PRIO2:  rd_byte = prio_eff_two;
         irq_pkg::REG_RCAUSE: rd_byte = rcause_q;
         irq_pkg::REG_TLOW:   rd_byte = tlow_q;
         irq_pkg::REG_THIGH:  rd_byte = thigh_q;
         irq_pkg::REG_TCFG:   rd_byte = {7'h00, sixteen_q};
         default:             rd_byte = irq_pkg::BYTE_ZERO;
      endcase
   end

   // Read data and error captured in setup, shown in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (rd_setup) begin
         prdata  <= {24'h00_0000, rd_byte};
         pslverr <= (idx == irq_pkg::REG_NONE);
      end
   end

   // Priority routing
   assign priority_levels_enable = rcause_q[irq_pkg::PRIO_LEVELS_EN_BIT];
   assign global_irq_enable  = main_ctl_q[irq_pkg::GLOBAL_IRQ_ENABLE_BIT];
   assign peripheral_irq_enable = main_ctl_q[irq_pkg::PERIPH_IRQ_ENABLE_BIT];
   assign ext_en = {third_ctl_q[irq_pkg::EXT_TWO_EN_BIT],
                    third_ctl_q[irq_pkg::EXT_ONE_EN_BIT],
                    main_ctl_q[irq_pkg::EXT_ZERO_EN_BIT]};
   assign p_ext  = ext_flag_q & ext_en;
   assign p_tmr  = timer_flag_q & main_ctl_q[irq_pkg::TIMER_ZERO_EN_BIT];
   assign p_port = port_flag_q & main_ctl_q[irq_pkg::PORT_CHANGE_EN_BIT];
   assign prio_eff_two = prio_two_q & irq_pkg::PERIPHERAL_PRIO_2_MASK;
   assign prio_eff_one = periph_one_prio;
   assign core_pend = (|p_ext) | p_tmr | p_port;
   assign core_high = p_ext[0]
                    | (p_ext[1] & third_ctl_q[irq_pkg::EXT_ONE_PRIO_BIT])
                    | (p_ext[2] & third_ctl_q[irq_pkg::EXT_TWO_PRIO_BIT])
                    | (p_tmr & second_ctl_q[irq_pkg::TIMER_ZERO_PRIO_BIT])
                    | (p_port & second_ctl_q[irq_pkg::PORT_CHANGE_PRIO_BIT]);
   assign core_low  = (p_ext[1] & ~third_ctl_q[irq_pkg::EXT_ONE_PRIO_BIT])
                    | (p_ext[2] & ~third_ctl_q[irq_pkg::EXT_TWO_PRIO_BIT])
                    | (p_tmr & ~second_ctl_q[irq_pkg::TIMER_ZERO_PRIO_BIT])
                    | (p_port & ~second_ctl_q[irq_pkg::PORT_CHANGE_PRIO_BIT]);
   assign high_any = core_high | (|(periph_two_pending & prio_eff_two))
                   | (|(periph_one_pending & prio_eff_one));
   assign low_any  = core_low | (|(periph_two_pending & ~prio_eff_two))
                   | (|(periph_one_pending & ~prio_eff_one));

   // Requests to the core and wake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_high_q <= 1'b0;
         irq_low_q  <= 1'b0;
         wake_q     <= 1'b0;
      end else begin
         if (priority_levels_enable) begin
            irq_high_q <= global_irq_enable & high_any;
            irq_low_q  <= global_irq_enable & peripheral_irq_enable & low_any;
         end else begin
            irq_high_q <= global_irq_enable & (core_pend | (peripheral_irq_enable & ((|periph_two_pending)
                        | (|periph_one_pending))));
            irq_low_q  <= 1'b0;
         end
         wake_q <= |p_ext;
      end
   end

   // Context save on interrupt entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_push_q     <= 1'b0;
         stack_pc_q       <= 21'h00_0000;
         shadow_working_q <= irq_pkg::BYTE_ZERO;
         shadow_status_q  <= irq_pkg::BYTE_ZERO;
         shadow_bank_q    <= irq_pkg::BYTE_ZERO;
      end else begin
         stack_push_q <= irq_entry;
         if (irq_entry) begin
            stack_pc_q       <= return_pc;
            shadow_working_q <= working_register;
            shadow_status_q  <= status_register;
            shadow_bank_q    <= bank_select_register;
         end
      end
   end

endmodule : irq_ctrl

/* dv/irq_ctrl_sva.sv */
`timescale 1ns/1ps

// Port-level checks on the bus answer and on context capture
module irq_ctrl_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        irq_entry,
   input wire logic [20:0] return_pc,
   input wire logic [7:0]  working_register,
   input wire logic [7:0]  status_register,
   input wire logic [7:0]  bank_select_register,
   input wire logic        stack_push_q,
   input wire logic [20:0] stack_pc_q,
   input wire logic [7:0]  shadow_working_q,
   input wire logic [7:0]  shadow_status_q,
   input wire logic [7:0]  shadow_bank_q
);
   logic rd;
   // Read access phase
   assign rd = psel && penable && !pwrite;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_ENTRY_PUSH: assert property (irq_entry |=> stack_push_q)
      else $error("no push after entry");
   AST_PUSH_CAUSE: assert property (stack_push_q |-> $past(irq_entry))
      else $error("push without entry");
   AST_PC_SAVE: assert property (irq_entry |=> stack_pc_q == $past(return_pc))
      else $error("return address not saved");
   AST_SHADOW_SAVE: assert property (irq_entry |=>
      shadow_working_q == $past(working_register) && shadow_status_q == $past(status_register)
      && shadow_bank_q == $past(bank_select_register))
      else $error("shadow copy wrong");
   AST_SHADOW_HOLD: assert property (!irq_entry |=>
      $stable(shadow_working_q) && $stable(stack_pc_q) && $stable(shadow_bank_q))
      else $error("capture changed without entry");
   AST_UPPER_ZERO: assert property (rd |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   AST_PRIO2_GAP: assert property (rd && paddr == irq_pkg::PERIPHERAL_PRIO_2_OFS
      |-> !prdata[5])
      else $error("priority gap bit set");
   AST_RCAUSE_GAP: assert property (rd && paddr == irq_pkg::RESET_CAUSE_CTRL_OFS
      |-> !prdata[5])
      else $error("reset control gap bit set");
endmodule : irq_ctrl_sva

bind irq_ctrl irq_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .irq_entry(irq_entry), .return_pc(return_pc), .working_register(working_register),
   .status_register(status_register), .bank_select_register(bank_select_register),
   .stack_push_q(stack_push_q), .stack_pc_q(stack_pc_q),
   .shadow_working_q(shadow_working_q), .shadow_status_q(shadow_status_q),
   .shadow_bank_q(shadow_bank_q));

/* dv/core_model.sv */
`timescale 1ns/1ps

// Core stand-in: one entry per new request, after a set latency
module core_model #(
   parameter int LATENCY = 2
) (
   input  wire logic   pclk,
   input  wire logic   presetn,
   input  wire logic   irq_high_q,
   input  wire logic   irq_low_q,
   output logic        irq_entry,
   output logic [20:0] return_pc,
   output logic [7:0]  working_register,
   output logic [7:0]  status_register,
   output logic [7:0]  bank_select_register
);
   logic       req_q;
   logic [7:0] cnt_q;
   int         wait_q;
   // Context moves every cycle so a stale capture shows
   assign return_pc            = {13'h0000, cnt_q};
   assign working_register     = cnt_q; // handler without fast return saves these
   assign status_register      = ~cnt_q;
   assign bank_select_register = cnt_q ^ 8'h5A;
   // Free-running context counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_q <= 8'h00;
      else cnt_q <= cnt_q + 8'h01;
   end
   // Entry pulse on each rising request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q     <= 1'b0;
         wait_q    <= 0;
         irq_entry <= 1'b0;
      end else begin
         req_q     <= irq_high_q | irq_low_q;
         irq_entry <= (wait_q == 1);
         if ((irq_high_q | irq_low_q) && !req_q) wait_q <= LATENCY;
         else if (wait_q > 0) wait_q <= wait_q - 1;
      end
   end
endmodule : core_model

/* dv/irq_ctrl_tb.sv */
`timescale 1ns/1ps

module irq_ctrl_tb;
   localparam logic [7:0] MN = irq_pkg::MAIN_IRQ_CONTROL_OFS;
   localparam logic [7:0] SC = irq_pkg::SECOND_IRQ_CONTROL_OFS;
   localparam logic [7:0] TH = irq_pkg::THIRD_IRQ_CONTROL_OFS;
   localparam logic [7:0] PR = irq_pkg::PERIPHERAL_PRIO_2_OFS;
   localparam logic [7:0] RC = irq_pkg::RESET_CAUSE_CTRL_OFS;
   localparam logic [7:0] TL = irq_pkg::TIMER_ZERO_LOW_OFS;
   localparam logic [7:0] TU = irq_pkg::TIMER_ZERO_HIGH_OFS;
   localparam logic [7:0] TC = irq_pkg::TIMER_ZERO_CONFIG_OFS;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tz, wdt, pdn, err;
   logic irq_high_q, irq_low_q, wake_q, irq_entry, stack_push_q;
   logic [7:0]  paddr, p2, p1, p1p, wr_reg, st_reg, bk_reg, sh_w, sh_s, sh_b;
   logic [31:0] pwdata, prdata, rdat;
   logic [2:0]  ext;
   logic [3:0]  pb;
   logic [20:0] rpc, spc;
   int          fail_count, total_checks;

   irq_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .ext_irq_pins(ext), .port_b_pins(pb), .timer_zero_tick(tz),
      .periph_two_pending(p2), .periph_one_pending(p1), .periph_one_prio(p1p),
      .watchdog_timeout_flag(wdt), .power_down_flag(pdn), .irq_entry(irq_entry),
      .return_pc(rpc), .working_register(wr_reg), .status_register(st_reg),
      .bank_select_register(bk_reg), .irq_high_q(irq_high_q), .irq_low_q(irq_low_q),
      .wake_q(wake_q), .stack_push_q(stack_push_q), .stack_pc_q(spc),
      .shadow_working_q(sh_w), .shadow_status_q(sh_s), .shadow_bank_q(sh_b));
   core_model #(.LATENCY(2)) u_core (.pclk(pclk), .presetn(presetn),
      .irq_high_q(irq_high_q), .irq_low_q(irq_low_q), .irq_entry(irq_entry),
      .return_pc(rpc), .working_register(wr_reg), .status_register(st_reg),
      .bank_select_register(bk_reg));

   // Clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      test_done();
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done();
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      repeat (20) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) begin
         fail_count++;
         test_done();
      end
      rdat = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(rdat, e);
   endtask : rd

   task automatic irq(input logic [1:0] e);
      repeat (3) @(posedge pclk);
      #1;
      check({30'h0000_0000, irq_high_q, irq_low_q}, {30'h0000_0000, e});
   endtask : irq

   task automatic tick(input int n);
      @(posedge pclk);
      tz <= 1'b1;
      repeat (n) @(posedge pclk);
      tz <= 1'b0;
   endtask : tick

   task automatic pins(input logic [2:0] e, input logic [3:0] b);
      @(posedge pclk);
      ext <= e;
      pb  <= b;
      repeat (8) @(posedge pclk);
   endtask : pins

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, tz, paddr, pwdata, ext, pb, p2, p1, p1p} = '0;
      {fail_count, total_checks, wdt, pdn} = {32'h0000_0000, 32'h0000_0000, 2'h3};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(MN, 32'h0000_0000);
      rd(SC, 32'h0000_0075);
      rd(TH, 32'h0000_00C0);
      rd(PR, 32'h0000_00DF);
      rd(RC, 32'h0000_005C);
      wr(PR, 32'h0000_00FF);
      rd(PR, 32'h0000_00DF);
      wr(PR, 32'h0000_0000);
      rd(PR, 32'h0000_0000);
      wr(RC, 32'h0000_00FF);
      rd(RC, 32'h0000_00DF);
      wr(RC, 32'h0000_0000);
      @(posedge pclk) wdt <= 1'b0;
      rd(RC, 32'h0000_0004);
      rd(8'h40, 32'h0000_0000);
      check({31'h0000_0000, err}, 32'h0000_0001);
      wr(8'h40, 32'h0000_00FF);
      check({31'h0000_0000, err}, 32'h0000_0001);
      pins(3'h1, 4'h0);
      rd(MN, 32'h0000_0002);
      wr(SC, 32'h0000_0035);
      wr(MN, 32'h0000_0000);
      pins(3'h6, 4'h0);
      rd(MN, 32'h0000_0002);
      rd(TH, 32'h0000_00C3);
      wr(MN, 32'h0000_0092);
      irq(2'b10);
      check({31'h0000_0000, wake_q}, 32'h0000_0001);
      wr(MN, 32'h0000_0002);
      irq(2'b00);
      check({31'h0000_0000, wake_q}, 32'h0000_0000);
      wr(RC, 32'h0000_0080);
      wr(MN, 32'h0000_00D2);
      irq(2'b10);
      wr(MN, 32'h0000_00C0);
      wr(TH, 32'h0000_0009);
      irq(2'b01);
      wr(TH, 32'h0000_0049);
      irq(2'b10);
      wr(TH, 32'h0000_0009);
      wr(RC, 32'h0000_0000);
      irq(2'b10);
      wr(TH, 32'h0000_0000);
      wr(MN, 32'h0000_0080);
      @(posedge pclk) p2 <= 8'h01;
      irq(2'b00);
      wr(MN, 32'h0000_00C0);
      irq(2'b10);
      wr(RC, 32'h0000_0080);
      irq(2'b01);
      wr(PR, 32'h0000_0001);
      irq(2'b10);
      @(posedge pclk) {p2, p1} <= {8'h00, 8'h02};
      irq(2'b01);
      @(posedge pclk) p1p <= 8'h02;
      irq(2'b10);
      @(posedge pclk) {p1, p1p} <= {8'h00, 8'h00};
      wr(RC, 32'h0000_0000);
      wr(TL, 32'h0000_00FE);
      tick(2);
      rd(MN, 32'h0000_00C4);
      rd(TL, 32'h0000_0000);
      wr(MN, 32'h0000_00E0);
      wr(TC, 32'h0000_0001);
      wr(TL, 32'h0000_00FF);
      wr(TU, 32'h0000_0000);
      tick(1);
      rd(MN, 32'h0000_00E0);
      rd(TU, 32'h0000_0001);
      wr(TL, 32'h0000_00FF);
      wr(TU, 32'h0000_00FF);
      tick(1);
      rd(MN, 32'h0000_00E4);
      irq(2'b10);
      wr(RC, 32'h0000_0080);
      wr(SC, 32'h0000_0031);
      irq(2'b01);
      wr(MN, 32'h0000_00C8);
      pins(3'h6, 4'h8);
      rd(MN, 32'h0000_00C9);
      irq(2'b10);
      wr(SC, 32'h0000_0030);
      irq(2'b01);
      test_done();
   end
endmodule : irq_ctrl_tb
